/* shared/jlsc_defs.svh */
`ifndef JLSC_DEFS_SVH
`define JLSC_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define JLSC_ADDR_REF_EVAL 16'h061C
`define JLSC_ADDR_NEG_EVAL 16'h061E
`define JLSC_ADDR_POS_EVAL 16'h0620
`define JLSC_ADDR_PEAK_CUR 16'h0D0C
`define JLSC_ADDR_STILL_CUR 16'h0D26
`define JLSC_ADDR_QSTOP_CUR 16'h110A
`define JLSC_ADDR_HALT_CUR 16'h110C
`define JLSC_ADDR_JOG_WORD 16'h1B12
`define JLSC_ADDR_LOW_SPEED 16'h2908
`define JLSC_ADDR_HIGH_SPEED 16'h290A
`define JLSC_ADDR_INCH_DIST 16'h290E
`define JLSC_ADDR_INCH_WAIT 16'h2910

// ****************************************
// reset values
// ****************************************
`define JLSC_RST_EVAL 16'h0001
`define JLSC_RST_JOG_WORD 16'h0000
`define JLSC_RST_LOW_SPEED 16'h003C
`define JLSC_RST_HIGH_SPEED 16'h00B4
`define JLSC_RST_INCH_DIST 32'h0000_0014
`define JLSC_RST_INCH_WAIT 16'h01F4
`define JLSC_RST_HALT_CUR 16'h0064
`define JLSC_RST_QSTOP_CUR 16'h0064

// ****************************************
// field positions and value ranges
// ****************************************
`define JLSC_JOG_CW_BIT 0
`define JLSC_JOG_CCW_BIT 1
`define JLSC_JOG_FAST_BIT 2
`define JLSC_JOG_WORD_MAX 32'h0000_0007
`define JLSC_EVAL_OFF 2'h0
`define JLSC_EVAL_NC 2'h1
`define JLSC_EVAL_NO 2'h2
`define JLSC_EVAL_MAX 32'h0000_0002
`define JLSC_SPEED_MIN 32'h0000_0001
`define JLSC_SPEED_MAX 32'h0000_3390
`define JLSC_WAIT_MIN 32'h0000_0001
`define JLSC_WAIT_MAX 32'h0000_7FFF
`define JLSC_CUR_MAX 32'h0000_FFFF
`define JLSC_INCH_SIGN_BIT 31

// ****************************************
// timing
// ****************************************
`define JLSC_CLK_KHZ 10000
`define JLSC_MS_UNIT 1
`define JLSC_MS_CYCLES (`JLSC_CLK_KHZ * `JLSC_MS_UNIT)

`endif

/* shared/jlsc_pkg.sv */
// ****************************************
// shared types
// ****************************************
package jlsc_pkg;
  typedef enum logic [1:0] {
    JLSC_IDLE,
    JLSC_INCH,
    JLSC_WAIT,
    JLSC_CONT
  } jlsc_jog_state_t;
  typedef logic [15:0] jlsc_half_t;
endpackage

/* shared/jlsc_sw_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// one switch channel between top and evaluator
// ****************************************
interface jlsc_sw_if;
  logic [1:0] eval_mode;
  logic raw_pin;
  logic hit;
  modport evaluator (input eval_mode, input raw_pin, output hit);
  modport owner (output eval_mode, output raw_pin, input hit);
endinterface
`default_nettype wire

/* verilog/jlsc_switch_eval.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jlsc_defs.svh"
module jlsc_switch_eval
  import jlsc_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, high
  jlsc_sw_if.evaluator sw // switch channel
);
  logic sync1_q;
  logic sync2_q;
  logic hit_q;
  logic hit_d;

  // ****************************************
  // pin synchroniser
  // ****************************************
  // the pin is asynchronous; only sync2_q is looked at
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      // start at the closed-contact idle level so no false trip follows reset
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= sw.raw_pin;
      sync2_q <= sync1_q;
    end
  end

  // contact decode: closed contact trips on low, open contact on high
  assign hit_d = (sw.eval_mode == `JLSC_EVAL_NC) ? !sync2_q :
                 (sw.eval_mode == `JLSC_EVAL_NO) ? sync2_q : 1'b0;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hit_q <= 1'b0;
    else
      hit_q <= hit_d;
  end
  assign sw.hit = hit_q;

  a_nc_contact_trip: assert property (@(posedge core_clk) disable iff (rst)
    (sw.eval_mode == `JLSC_EVAL_NC) && !sync2_q |=> hit_q)
    else $error("closed contact open but no trip");
endmodule
`default_nettype wire

/* verilog/jlsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jlsc_defs.svh"
module jlsc_top
  import jlsc_pkg::*;
#(
  parameter int MS_CYCLES = `JLSC_MS_CYCLES // clock cycles per millisecond
)
(
  input wire logic core_clk, // 10 MHz clock
  input wire logic rst, // async reset, high
  input wire logic [15:0] reg_addr, // parameter address
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  input wire logic [31:0] reg_wdata, // write data
  output logic [31:0] reg_rdata, // read data
  output logic reg_ack, // access done pulse
  output logic reg_err, // refused access pulse
  input wire logic negative_limit_input, // limit pin, async
  input wire logic positive_limit_input, // limit pin, async
  input wire logic reference_switch_input, // reference pin, async
  input wire logic ref_move_active, // reference move toward switch
  input wire logic [15:0] ramp_speed_ceiling, // ramp max speed
  input wire logic halt_braking, // braking after halt
  input wire logic quickstop_braking, // braking on torque ramp
  input wire logic [15:0] motor_peak_current_in, // motor data
  input wire logic [15:0] motor_standstill_current_in, // motor data
  input wire logic inch_done, // step positioning finished
  output logic negative_limit_hit, // negative limit tripped
  output logic positive_limit_hit, // positive limit tripped
  output logic ref_switch_hit, // reference tripped
  output logic jog_cw, // jog moving clockwise
  output logic jog_ccw, // jog moving counterclockwise
  output logic jog_continuous, // continuous jog phase
  output logic [15:0] jog_speed_cmd, // effective jog speed
  output logic inch_start, // start step pulse
  output logic [31:0] inch_step, // step distance
  output logic [15:0] current_limit // active current limit
);
  // ****************************************
  // registers
  // ****************************************
  jlsc_half_t ref_eval_q;
  jlsc_half_t neg_eval_q;
  jlsc_half_t pos_eval_q;
  jlsc_half_t qstop_cur_q;
  jlsc_half_t halt_cur_q;
  jlsc_half_t jog_word_q;
  jlsc_half_t low_speed_q;
  jlsc_half_t high_speed_q;
  logic [31:0] inch_dist_q;
  jlsc_half_t inch_wait_q;
  logic [31:0] rdata_q;
  logic ack_q;
  logic err_q;

  // ****************************************
  // address decode and value checks
  // ****************************************
  wire a_ref = (reg_addr == `JLSC_ADDR_REF_EVAL);
  wire a_neg = (reg_addr == `JLSC_ADDR_NEG_EVAL);
  wire a_pos = (reg_addr == `JLSC_ADDR_POS_EVAL);
  wire a_peak = (reg_addr == `JLSC_ADDR_PEAK_CUR);
  wire a_still = (reg_addr == `JLSC_ADDR_STILL_CUR);
  wire a_qstop = (reg_addr == `JLSC_ADDR_QSTOP_CUR);
  wire a_halt = (reg_addr == `JLSC_ADDR_HALT_CUR);
  wire a_jog = (reg_addr == `JLSC_ADDR_JOG_WORD);
  wire a_low = (reg_addr == `JLSC_ADDR_LOW_SPEED);
  wire a_high = (reg_addr == `JLSC_ADDR_HIGH_SPEED);
  wire a_dist = (reg_addr == `JLSC_ADDR_INCH_DIST);
  wire a_wait = (reg_addr == `JLSC_ADDR_INCH_WAIT);
  wire a_known = a_ref | a_neg | a_pos | a_peak | a_still | a_qstop | a_halt |
                 a_jog | a_low | a_high | a_dist | a_wait;

  // a rejected value leaves the old setting in place
  wire ok_lim = (reg_wdata <= `JLSC_EVAL_MAX);
  wire ok_ref = (reg_wdata >= 32'h0000_0001) && (reg_wdata <= `JLSC_EVAL_MAX);
  wire ok_jog = (reg_wdata <= `JLSC_JOG_WORD_MAX);
  wire ok_speed = (reg_wdata >= `JLSC_SPEED_MIN) && (reg_wdata <= `JLSC_SPEED_MAX);
  wire ok_dist = !reg_wdata[`JLSC_INCH_SIGN_BIT];
  wire ok_wait = (reg_wdata >= `JLSC_WAIT_MIN) && (reg_wdata <= `JLSC_WAIT_MAX);
  wire ok_cur = (reg_wdata <= `JLSC_CUR_MAX);

  // motor data are read-only; writing them is refused
  wire wr_ok = (a_ref & ok_ref) | ((a_neg | a_pos) & ok_lim) |
               ((a_qstop | a_halt) & ok_cur) | (a_jog & ok_jog) |
               ((a_low | a_high) & ok_speed) | (a_dist & ok_dist) |
               (a_wait & ok_wait);
  wire wr_go = reg_wr & wr_ok;

  // read mux as and-or so the wires stay flat
  wire [31:0] rd_mux = ({32{a_ref}} & {16'h0000, ref_eval_q}) |
                       ({32{a_neg}} & {16'h0000, neg_eval_q}) |
                       ({32{a_pos}} & {16'h0000, pos_eval_q}) |
                       ({32{a_peak}} & {16'h0000, motor_peak_current_in}) |
                       ({32{a_still}} & {16'h0000, motor_standstill_current_in}) |
                       ({32{a_qstop}} & {16'h0000, qstop_cur_q}) |
                       ({32{a_halt}} & {16'h0000, halt_cur_q}) |
                       ({32{a_jog}} & {16'h0000, jog_word_q}) |
                       ({32{a_low}} & {16'h0000, low_speed_q}) |
                       ({32{a_high}} & {16'h0000, high_speed_q}) |
                       ({32{a_dist}} & inch_dist_q) |
                       ({32{a_wait}} & {16'h0000, inch_wait_q});

  // ****************************************
  // parameter storage
  // ****************************************
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ref_eval_q <= `JLSC_RST_EVAL;
      neg_eval_q <= `JLSC_RST_EVAL;
      pos_eval_q <= `JLSC_RST_EVAL;
      qstop_cur_q <= `JLSC_RST_QSTOP_CUR;
      halt_cur_q <= `JLSC_RST_HALT_CUR;
      jog_word_q <= `JLSC_RST_JOG_WORD;
      low_speed_q <= `JLSC_RST_LOW_SPEED;
      high_speed_q <= `JLSC_RST_HIGH_SPEED;
      inch_dist_q <= `JLSC_RST_INCH_DIST;
      inch_wait_q <= `JLSC_RST_INCH_WAIT;
    end
    else if (wr_go)
    begin
      if (a_ref) ref_eval_q <= reg_wdata[15:0];
      if (a_neg) neg_eval_q <= reg_wdata[15:0];
      if (a_pos) pos_eval_q <= reg_wdata[15:0];
      if (a_qstop) qstop_cur_q <= reg_wdata[15:0];
      if (a_halt) halt_cur_q <= reg_wdata[15:0];
      if (a_jog) jog_word_q <= reg_wdata[15:0];
      if (a_low) low_speed_q <= reg_wdata[15:0];
      if (a_high) high_speed_q <= reg_wdata[15:0];
      if (a_dist) inch_dist_q <= reg_wdata;
      if (a_wait) inch_wait_q <= reg_wdata[15:0];
    end
  end

  // access answer one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      rdata_q <= (reg_rd & a_known) ? rd_mux : 32'h0000_0000;
      ack_q <= reg_wr | reg_rd;
      err_q <= (reg_wr & !wr_ok) | (reg_rd & !a_known);
    end
  end
  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign reg_err = err_q;

  // ****************************************
  // switch evaluation
  // ****************************************
  jlsc_sw_if neg_sw ();
  jlsc_sw_if pos_sw ();
  jlsc_sw_if ref_sw ();
  assign neg_sw.eval_mode = neg_eval_q[1:0];
  assign neg_sw.raw_pin = negative_limit_input;
  assign pos_sw.eval_mode = pos_eval_q[1:0];
  assign pos_sw.raw_pin = positive_limit_input;
  assign ref_sw.eval_mode = ref_eval_q[1:0];
  assign ref_sw.raw_pin = reference_switch_input;

  jlsc_switch_eval u_neg (.core_clk(core_clk), .rst(rst), .sw(neg_sw));
  jlsc_switch_eval u_pos (.core_clk(core_clk), .rst(rst), .sw(pos_sw));
  jlsc_switch_eval u_ref (.core_clk(core_clk), .rst(rst), .sw(ref_sw));
  assign negative_limit_hit = neg_sw.hit;
  assign positive_limit_hit = pos_sw.hit;

  logic ref_hit_q;
  // reference trip is masked outside a reference move
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ref_hit_q <= 1'b0;
    else
      ref_hit_q <= ref_sw.hit & ref_move_active;
  end
  assign ref_switch_hit = ref_hit_q;

  // ****************************************
  // jog sequencer
  // ****************************************
  jlsc_jog_state_t state_q;
  jlsc_jog_state_t state_d;
  logic dir_cw_q;
  logic [15:0] ms_div_q;
  logic [15:0] wait_left_q;
  logic inch_start_q;
  logic [15:0] speed_q;

  wire req_cw = jog_word_q[`JLSC_JOG_CW_BIT];
  wire req_ccw = jog_word_q[`JLSC_JOG_CCW_BIT];
  wire req_fast = jog_word_q[`JLSC_JOG_FAST_BIT];
  // both bits together is treated as no request
  wire req_valid = req_cw ^ req_ccw;
  // a direction flip restarts the cycle through idle
  wire req_keep = req_valid & (req_cw == dir_cw_q);
  wire inch_zero = (inch_dist_q == 32'h0000_0000);
  wire ms_tick = (ms_div_q == 16'(MS_CYCLES - 1));
  wire wait_end = ms_tick & (wait_left_q == 16'h0001);

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      JLSC_IDLE:
        if (req_valid)
          state_d = inch_zero ? JLSC_CONT : JLSC_INCH;
      JLSC_INCH:
        if (!req_keep)
          state_d = JLSC_IDLE;
        else if (inch_done)
          state_d = JLSC_WAIT;
      JLSC_WAIT:
        if (!req_keep)
          state_d = JLSC_IDLE;
        else if (wait_end)
          state_d = JLSC_CONT;
      JLSC_CONT:
        if (!req_keep)
          state_d = JLSC_IDLE;
      default:
        state_d = JLSC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= JLSC_IDLE;
      dir_cw_q <= 1'b0;
      inch_start_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == JLSC_IDLE)
        dir_cw_q <= req_cw;
      inch_start_q <= (state_q == JLSC_IDLE) & (state_d == JLSC_INCH);
    end
  end

  // wait timer: millisecond prescaler plus millisecond down-counter
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ms_div_q <= 16'h0000;
      wait_left_q <= 16'h0000;
    end
    else if (state_q != JLSC_WAIT)
    begin
      ms_div_q <= 16'h0000;
      wait_left_q <= inch_wait_q;
    end
    else if (ms_tick)
    begin
      ms_div_q <= 16'h0000;
      wait_left_q <= wait_left_q - 16'h0001;
    end
    else
      ms_div_q <= ms_div_q + 16'h0001;
  end

  // speed select and clamp; the stored setting keeps the written value
  wire [15:0] speed_sel = req_fast ? high_speed_q : low_speed_q;
  wire [15:0] speed_eff = (speed_sel > ramp_speed_ceiling) ? ramp_speed_ceiling : speed_sel;
  wire moving = (state_q == JLSC_INCH) | (state_q == JLSC_CONT);

  logic cw_q;
  logic ccw_q;
  logic cont_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      speed_q <= 16'h0000;
      cw_q <= 1'b0;
      ccw_q <= 1'b0;
      cont_q <= 1'b0;
    end
    else
    begin
      speed_q <= speed_eff;
      cw_q <= moving & dir_cw_q;
      ccw_q <= moving & !dir_cw_q;
      cont_q <= (state_q == JLSC_CONT);
    end
  end
  assign jog_speed_cmd = speed_q;
  assign jog_cw = cw_q;
  assign jog_ccw = ccw_q;
  assign jog_continuous = cont_q;
  assign inch_start = inch_start_q;
  assign inch_step = inch_dist_q;

  // ****************************************
  // braking current limit
  // ****************************************
  // quick stop wins when both braking kinds overlap
  logic [15:0] cur_lim_q;
  wire [15:0] cur_sel = quickstop_braking ? qstop_cur_q :
                        halt_braking ? halt_cur_q :
                        motor_peak_current_in;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cur_lim_q <= 16'h0000;
    else
      cur_lim_q <= cur_sel;
  end
  assign current_limit = cur_lim_q;

  // ****************************************
  // checks
  // ****************************************
  a_neg_eval_off: assert property (@(posedge core_clk) disable iff (rst)
    $past(neg_eval_q[1:0] == `JLSC_EVAL_OFF) |-> !negative_limit_hit)
    else $error("disabled negative limit tripped");
  a_ref_eval_set: assert property (@(posedge core_clk) disable iff (rst)
    (ref_eval_q == 16'h0001) || (ref_eval_q == 16'h0002))
    else $error("reference evaluation out of range");
  a_ref_gate_off: assert property (@(posedge core_clk) disable iff (rst)
    !$past(ref_move_active) |-> !ref_switch_hit)
    else $error("reference trip outside reference move");
  a_jog_word_range: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && a_jog && (reg_wdata > 32'h0000_0007) |=> reg_err && $stable(jog_word_q))
    else $error("bad jog word accepted");
  a_speed_bounds: assert property (@(posedge core_clk) disable iff (rst)
    (high_speed_q >= 16'h0001) && (high_speed_q <= 16'h3390) &&
    (low_speed_q >= 16'h0001) && (low_speed_q <= 16'h3390))
    else $error("jog speed setting out of range");
  a_speed_clamp: assert property (@(posedge core_clk) disable iff (rst)
    ##1 jog_speed_cmd <= $past(ramp_speed_ceiling))
    else $error("jog speed above ramp ceiling");
  a_inch_skip: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == JLSC_IDLE) && req_valid && inch_zero |=> (state_q == JLSC_CONT) && !inch_start)
    else $error("zero step did not go continuous");
  a_inch_first: assert property (@(posedge core_clk) disable iff (rst)
    (state_q == JLSC_IDLE) && req_valid && !inch_zero |=>
    ((state_q == JLSC_INCH) && inch_start) ##1 (!inch_start && (jog_cw || jog_ccw)))
    else $error("step not started");
  a_wait_hold: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_q == JLSC_WAIT) && (wait_left_q >= 16'h0002) |-> (state_q != JLSC_CONT) [*8])
    else $error("wait ended too early");
  a_halt_limit: assert property (@(posedge core_clk) disable iff (rst)
    halt_braking && !quickstop_braking |=> current_limit == $past(halt_cur_q))
    else $error("halt current limit wrong");
  a_qstop_limit: assert property (@(posedge core_clk) disable iff (rst)
    quickstop_braking |=> current_limit == $past(qstop_cur_q))
    else $error("quick stop current limit wrong");
  a_ro_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && (a_peak || a_still) |=> reg_ack && reg_err)
    else $error("write to motor data accepted");
  a_jog_stop: assert property (@(posedge core_clk) disable iff (rst)
    !req_valid |=> (state_q == JLSC_IDLE) ##1 (!jog_cw && !jog_ccw))
    else $error("jog kept moving without request");
endmodule
`default_nettype wire

/* tb/jlsc_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// switches and step positioning seen from the drive
// ****************************************
module jlsc_partner
(
  input wire logic core_clk, // system clock
  input wire logic [2:0] pressed, // neg, pos, ref actuated
  input wire logic [2:0] open_type, // contact closes when actuated
  input wire logic inch_start, // step begins
  input wire logic [7:0] done_delay, // cycles until step done
  output logic negative_limit_input, // negative limit pin
  output logic positive_limit_input, // positive limit pin
  output logic reference_switch_input, // reference pin
  output logic inch_done // step finished
);
  logic [7:0] cnt_q;
  logic busy_q;
  // a closed contact opens when actuated, an open one closes
  assign negative_limit_input = pressed[0] ~^ open_type[0];
  assign positive_limit_input = pressed[1] ~^ open_type[1];
  assign reference_switch_input = pressed[2] ~^ open_type[2];
  // done comes as a one-cycle pulse; a long delay models a slow axis
  assign inch_done = busy_q && (cnt_q == 8'h00);
  always @(posedge core_clk)
  begin
    if (inch_start)
    begin
      busy_q <= 1'b1;
      cnt_q <= done_delay;
    end
    else if (busy_q)
    begin
      busy_q <= (cnt_q != 8'h00);
      cnt_q <= cnt_q - 8'h01;
    end
  end
  initial busy_q = 1'b0;
  initial cnt_q = 8'h00;
endmodule
`default_nettype wire

/* tb/jog_and_limit_switch_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jlsc_defs.svh"
module jog_and_limit_switch_control_tb_top;
  import jlsc_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ref_move_active = 1'b0;
  logic halt_braking = 1'b0, quickstop_braking = 1'b0, reg_ack, reg_err, inch_done, inch_start;
  logic neg_pin, pos_pin, ref_pin, negative_limit_hit, positive_limit_hit, ref_switch_hit;
  logic jog_cw, jog_ccw, jog_continuous;
  logic [15:0] reg_addr = 16'h0000, ramp_speed_ceiling = 16'h3390, jog_speed_cmd, current_limit;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, inch_step, rd;
  logic [2:0] pressed = 3'h0, open_type = 3'h0;
  logic [7:0] done_delay = 8'h02;
  int err_count = 0, check_count = 0;
  // ****************************************
  // clock, design and far side
  // ****************************************
  always #50 core_clk = ~core_clk;
  jlsc_top #(.MS_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .negative_limit_input(neg_pin),
    .positive_limit_input(pos_pin), .reference_switch_input(ref_pin),
    .ref_move_active(ref_move_active), .ramp_speed_ceiling(ramp_speed_ceiling),
    .halt_braking(halt_braking), .quickstop_braking(quickstop_braking),
    .motor_peak_current_in(16'h0190), .motor_standstill_current_in(16'h00C8),
    .inch_done(inch_done), .negative_limit_hit(negative_limit_hit),
    .positive_limit_hit(positive_limit_hit), .ref_switch_hit(ref_switch_hit), .jog_cw(jog_cw),
    .jog_ccw(jog_ccw), .jog_continuous(jog_continuous), .jog_speed_cmd(jog_speed_cmd),
    .inch_start(inch_start), .inch_step(inch_step), .current_limit(current_limit));
  jlsc_partner far_side (.core_clk(core_clk), .pressed(pressed), .open_type(open_type),
    .inch_start(inch_start), .done_delay(done_delay), .negative_limit_input(neg_pin),
    .positive_limit_input(pos_pin), .reference_switch_input(ref_pin), .inch_done(inch_done));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one access: strobe held over one sampling edge, answer taken right after it
  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] d,
    input logic exp_err);
    @(posedge core_clk);
    #1 reg_wr = wr;
    reg_rd = ~wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge core_clk);
    #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    rd = reg_rdata;
    chk({reg_ack, reg_err}, {1'b1, exp_err});
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [15:0] a[8] = '{16'h061C, 16'h061E, 16'h0620, 16'h1B12, 16'h2908, 16'h290A,
      16'h290E, 16'h2910};
    logic [31:0] v[8] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h3C, 32'hB4, 32'h14, 32'h1F4};
    logic [15:0] ba[12] = '{16'h061E, 16'h061C, 16'h061C, 16'h1B12, 16'h2908, 16'h290A,
      16'h290E, 16'h2910, 16'h2910, 16'h0D0C, 16'h0D26, 16'h110A};
    logic [31:0] bd[12] = '{32'h3, 32'h0, 32'h3, 32'h8, 32'h0, 32'h3391, 32'h8000_0000,
      32'h0, 32'h8000, 32'h1, 32'h1, 32'h1_0000};
    cyc(2);
    chk({negative_limit_hit, positive_limit_hit, ref_switch_hit}, 3'b000);
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, a[i], 32'h0, 1'b0);
      chk(rd, v[i]);
    end
    for (int i = 0; i < 12; i++)
      acc(1'b1, ba[i], bd[i], 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      acc(1'b0, a[i], 32'h0, 1'b0);
      chk(rd, v[i]);
    end
    acc(1'b0, 16'h0D0C, 32'h0, 1'b0);
    chk(rd, 32'h0190);
    acc(1'b0, 16'h0D26, 32'h0, 1'b0);
    chk(rd, 32'h00C8);
    acc(1'b0, 16'h0000, 32'h0, 1'b1);
    acc(1'b1, 16'h290A, 32'h3390, 1'b0);
    acc(1'b1, 16'h2908, 32'h1, 1'b0);
    $display("test registers done");
  endtask
  task automatic t_switch;
    open_type = 3'b110;
    acc(1'b1, 16'h0620, 32'h2, 1'b0);
    acc(1'b1, 16'h061C, 32'h2, 1'b0);
    pressed = 3'b111;
    cyc(5);
    chk({negative_limit_hit, positive_limit_hit, ref_switch_hit}, 3'b110);
    ref_move_active = 1'b1;
    cyc(5);
    chk(ref_switch_hit, 1'b1);
    pressed = 3'b000;
    cyc(5);
    chk({negative_limit_hit, positive_limit_hit, ref_switch_hit}, 3'b000);
    acc(1'b1, 16'h061E, 32'h0, 1'b0);
    pressed = 3'b001;
    cyc(5);
    chk(negative_limit_hit, 1'b0);
    pressed = 3'b000;
    ref_move_active = 1'b0;
    $display("test switches done");
  endtask
  task automatic t_jog;
    ramp_speed_ceiling = 16'h0064;
    acc(1'b1, 16'h2908, 32'h3C, 1'b0);
    acc(1'b1, 16'h290E, 32'h0, 1'b0);
    acc(1'b1, 16'h1B12, 32'h6, 1'b0);
    cyc(4);
    chk({jog_cw, jog_ccw, jog_continuous, inch_start}, 4'b0110);
    chk(jog_speed_cmd, 16'h0064);
    acc(1'b1, 16'h1B12, 32'h3, 1'b0);
    cyc(4);
    chk({jog_cw, jog_ccw, jog_continuous}, 3'b000);
    acc(1'b1, 16'h1B12, 32'h1, 1'b0);
    cyc(4);
    chk({jog_cw, jog_continuous, jog_speed_cmd}, {2'b11, 16'h003C});
    acc(1'b1, 16'h1B12, 32'h0, 1'b0);
    cyc(4);
    chk({jog_cw, jog_continuous}, 2'b00);
    acc(1'b1, 16'h290E, 32'h14, 1'b0);
    acc(1'b1, 16'h2910, 32'h3, 1'b0);
    done_delay = 8'h06;
    acc(1'b1, 16'h1B12, 32'h1, 1'b0);
    cyc(1);
    chk({inch_start, jog_cw}, 2'b10);
    chk(inch_step, 32'h14);
    cyc(1);
    chk({inch_start, jog_cw, jog_continuous}, 3'b010);
    cyc(10);
    chk({jog_cw, jog_continuous}, 2'b00);
    cyc(9);
    chk({jog_cw, jog_continuous}, 2'b00);
    cyc(1);
    chk({jog_cw, jog_continuous}, 2'b11);
    acc(1'b1, 16'h1B12, 32'h0, 1'b0);
    $display("test jog done");
  endtask
  task automatic t_current;
    acc(1'b1, 16'h110C, 32'h50, 1'b0);
    acc(1'b1, 16'h110A, 32'h30, 1'b0);
    cyc(2);
    chk(current_limit, 16'h0190);
    halt_braking = 1'b1;
    cyc(2);
    chk(current_limit, 16'h0050);
    quickstop_braking = 1'b1;
    cyc(2);
    chk(current_limit, 16'h0030);
    halt_braking = 1'b0;
    quickstop_braking = 1'b0;
    $display("test current done");
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1 rst = 1'b0;
    t_regs();
    t_switch();
    t_jog();
    t_current();
    summarize();
  end
  initial
  begin
    #400000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
